// *** pmc_host_model.sv ***
// management processor model driving the byte-wide control bus
module pmc_host_model (
    input  wire logic                   i_ref_clk,
    input  wire pmc_pkg::pmc_cbus_rsp_s i_cb_rsp,
    output pmc_pkg::pmc_cbus_req_s      o_cb_req
);
    timeunit 1ns;
    timeprecision 1ps;

    // bus idle with nothing selected at time zero
    initial begin
        o_cb_req = '0;
    end

    // one access: strobe for one edge, answer taken one cycle later
    task automatic access(input logic wr, input logic [5:0] addr,
                          input logic [7:0] data, input logic bad_par,
                          output pmc_pkg::pmc_cbus_rsp_s rsp);
        @(posedge i_ref_clk);
        o_cb_req.sel  <= 1'b1;
        o_cb_req.wr   <= wr;
        o_cb_req.addr <= addr;
        o_cb_req.data <= data;
        o_cb_req.par  <= (~^data) ^ bad_par;
        @(posedge i_ref_clk);
        o_cb_req.sel  <= 1'b0;
        o_cb_req.data <= ~data; // released data lines do not keep last value
        #1;
        rsp = i_cb_rsp;
    endtask
endmodule

// *** pmc_pkg.sv ***
// types shared by the mode and cmt condition register block
package pmc_pkg;
    typedef enum logic [1:0] {SC_IDLE, SC_INVALID, SC_SCRUB} pmc_scrub_e;
    typedef enum logic [1:0] {SYM_NONE, SYM_INVALID, SYM_SCRUB} pmc_sym_e;
    typedef struct packed {
        logic       sel;
        logic       wr;
        logic [5:0] addr;
        logic [7:0] data;
        logic       par;
    } pmc_cbus_req_s;
    typedef struct packed {
        logic       ack;
        logic [7:0] data;
        logic       par;
    } pmc_cbus_rsp_s;
    typedef struct packed {
        logic [7:0]  mode;
        logic [4:0]  srst_cnt;
        logic [1:0]  stat;
        logic [1:0]  cmp;
        pmc_cbus_rsp_s rsp;
        pmc_scrub_e  scrub;
        pmc_sym_e    sym;
        logic        inv_cnt;
        logic [8:0]  tick_cnt;
        logic [7:0]  thr_cnt;
        logic [7:0]  scrub_ports;
        logic        par_err;
        logic        conditional_write_inhibit;
        logic        connection_service_event;
        logic        tx_load;
        logic [2:0]  tx_mode;
        logic        cfg_load;
        logic [7:0]  cfg;
        logic [1:0]  div_cnt;
        logic        aux_sel;
        logic        aux_clk;
    } pmc_state_s;
endpackage

// *** pmc_regs.sv ***
// mode register two and cmt condition registers with scrub control
// How it works
// (R01) mode register writes ignored during reset
// (R02) reset bit resets phy function only
// (R03) reset bit self-clears after 32 byte times
// (R04) host only sets reset bit; zero ignored
// (R05) parity checked on writes only when enabled
// (R06) parity mismatch flags error, discards access
// (R07) read cycles always carry correct parity
// (R08) clock select resets slow; one gives fast
// (R09) aux clock switches rate without glitches
// (R10) trigger with scrub enable loads config, scrubs
// (R11) two invalid symbols, then scrub until timer
// (R12) status read copies into comparison register
// (R13) mismatching status write sets inhibit, no change
// (R14) status and mask both set raise service event
// (R15) scrub timer expiry sets timer-expired bit
// (R16) timer-expired bit protects port configuration
// (R17) trigger sets occurred bit, loads transmit mode
// (R18) occurred bit protects current transmit state
// (R19) host leaves reserved bits untouched
// (R20) scrub timer ticks every 40.96 microseconds; the code ticks every 409 cycles of 100 ns, 40.9 microseconds
// (R21) trigger definition selects trigger, transmit mode
// (R22) reserved bits read zero, ignore writes
`include "pmc_regs.svh"
module pmc_regs #(
    parameter bit PAR_ODD = 1'b1
) (
    input  wire logic                  i_ref_clk,
    input  wire logic                  i_rst_n,
    input  wire pmc_pkg::pmc_cbus_req_s i_cb,
    output pmc_pkg::pmc_cbus_rsp_s     o_cb,
    input  wire logic [7:0]            i_cmt_mask,
    input  wire logic                  i_trig_event,
    input  wire logic [2:0]            i_trig_tx_mode,
    input  wire logic [7:0]            i_trans_cfg,
    input  wire logic [7:0]            i_port_cfg,
    input  wire logic [7:0]            i_scrub_threshold,
    output logic                       o_phy_func_rst,
    output logic                       o_aux_clock_output,
    output logic                       o_par_err_set,
    output logic                       o_cwi_set,
    output logic                       o_cse_set,
    output logic                       o_tx_mode_load,
    output logic [2:0]                 o_tx_mode,
    output logic                       o_cfg_load,
    output logic [7:0]                 o_cfg,
    output logic [7:0]                 o_scrub_ports,
    output pmc_pkg::pmc_sym_e          o_scrub_sym,
    output logic                       o_port_cfg_protect,
    output logic                       o_tx_state_protect
);
    localparam logic [8:0] TICK_LAST = 9'(`PMC_TICK_CYC - 1);
    localparam logic [4:0] SRST_LAST = 5'(`PMC_SRST_CYC - 1);

    pmc_pkg::pmc_state_s r_reg;
    pmc_pkg::pmc_state_s r_next;

    logic       par_bad;
    logic       wr_acc;
    logic       rd_acc;
    logic       tick_done;
    logic       tmr_exp;
    logic       trig_scrub;
    logic [1:0] cmt_wr;
    logic [1:0] cmt_full;

    // access qualification and parity check
    assign par_bad = r_reg.mode[`PMC_MODE_HOST_BUS_PARITY_CHECK_ENABLE] & i_cb.sel & i_cb.wr
                   & (i_cb.par != (^i_cb.data ^ PAR_ODD)); // R05
    assign wr_acc = i_cb.sel & i_cb.wr & ~par_bad; // R06
    assign rd_acc = i_cb.sel & ~i_cb.wr;
    // scrub timer tick and expiry
    assign tick_done = (r_reg.tick_cnt == TICK_LAST); // R20
    assign tmr_exp = (r_reg.scrub == pmc_pkg::SC_SCRUB) & tick_done
                   & (r_reg.thr_cnt == 8'h00); // R20
    assign trig_scrub = i_trig_event & r_reg.mode[`PMC_MODE_SCRUB_ON_TRIGGER_ENABLE]; // R10
    assign cmt_wr = {i_cb.data[`PMC_CMT_TCO], i_cb.data[`PMC_CMT_STE]};

    // next state of every register of the block
    always_comb begin
        r_next = r_reg;
        r_next.par_err = par_bad; // R06
        r_next.conditional_write_inhibit = 1'b0;
        r_next.tx_load = 1'b0;
        r_next.cfg_load = 1'b0;
        r_next.rsp = '0;
        // software reset countdown
        if (r_reg.mode[`PMC_MODE_SRST]) begin
            r_next.srst_cnt = r_reg.srst_cnt + 5'h01;
            if (r_reg.srst_cnt == SRST_LAST) begin
                r_next.mode[`PMC_MODE_SRST] = 1'b0; // R03
                r_next.srst_cnt = 5'h00;
            end
        end
        // mode register write, ignored while the phy is in reset
        if (wr_acc && i_cb.addr == `PMC_OFS_MODE
                && !r_reg.mode[`PMC_MODE_SRST]) begin // R01
            r_next.mode = i_cb.data & 8'ha2; // R22
            r_next.mode[`PMC_MODE_SRST] = i_cb.data[0]; // R04
            r_next.srst_cnt = 5'h00;
        end
        // comparison register write
        if (wr_acc && i_cb.addr == `PMC_OFS_CMP) begin
            r_next.cmp = cmt_wr; // R22
        end
        // conditional status write
        if (wr_acc && i_cb.addr == `PMC_OFS_STAT) begin
            if (r_reg.stat != r_reg.cmp) begin
                r_next.conditional_write_inhibit = 1'b1; // R13
            end else begin
                r_next.stat = cmt_wr;
            end
        end
        // read path, status read snapshots into comparison register
        if (rd_acc) begin
            r_next.rsp.ack = 1'b1;
            case (i_cb.addr)
                `PMC_OFS_MODE: r_next.rsp.data = r_reg.mode;
                `PMC_OFS_CMP:  r_next.rsp.data = {r_reg.cmp, 6'h00};
                `PMC_OFS_STAT: begin
                    r_next.rsp.data = {r_reg.stat, 6'h00}; // R22
                    r_next.cmp = r_reg.stat; // R12
                end
                default:       r_next.rsp.data = 8'h00;
            endcase
        end else if (i_cb.sel) begin
            r_next.rsp.ack = 1'b1;
        end
        r_next.rsp.par = ^r_next.rsp.data ^ PAR_ODD; // R07
        // scrub sequencer
        case (r_reg.scrub)
            pmc_pkg::SC_IDLE: begin
                r_next.tick_cnt = 9'h000;
            end
            pmc_pkg::SC_INVALID: begin
                r_next.inv_cnt = 1'b1;
                if (r_reg.inv_cnt) begin
                    r_next.scrub = pmc_pkg::SC_SCRUB; // R11
                    r_next.tick_cnt = 9'h000;
                end
            end
            pmc_pkg::SC_SCRUB: begin
                r_next.tick_cnt = r_reg.tick_cnt + 9'h001;
                if (tick_done) begin
                    r_next.tick_cnt = 9'h000;
                    r_next.thr_cnt = r_reg.thr_cnt - 8'h01; // R20
                    if (tmr_exp) begin
                        r_next.scrub = pmc_pkg::SC_IDLE; // R11
                        r_next.scrub_ports = 8'h00;
                    end
                end
            end
            default: begin
                r_next.scrub = pmc_pkg::SC_IDLE;
            end
        endcase
        // trigger: transmit mode load and optional scrub start
        if (i_trig_event) begin
            r_next.tx_load = 1'b1; // R17
            r_next.tx_mode = i_trig_tx_mode; // R21
        end
        if (trig_scrub) begin
            r_next.cfg_load = 1'b1; // R10
            r_next.cfg = i_trans_cfg; // R10
            r_next.scrub_ports = i_trans_cfg ^ i_port_cfg; // R10
            r_next.scrub = pmc_pkg::SC_INVALID; // R11
            r_next.inv_cnt = 1'b0;
            r_next.thr_cnt = i_scrub_threshold;
            r_next.tick_cnt = 9'h000;
        end
        case (r_next.scrub)
            pmc_pkg::SC_INVALID: r_next.sym = pmc_pkg::SYM_INVALID;
            pmc_pkg::SC_SCRUB:   r_next.sym = pmc_pkg::SYM_SCRUB;
            default:             r_next.sym = pmc_pkg::SYM_NONE;
        endcase
        // hardware sets win over host clears
        if (tmr_exp) begin
            r_next.stat[0] = 1'b1; // R15
        end
        if (i_trig_event) begin
            r_next.stat[1] = 1'b1; // R17
        end
        // service event from status and mask
        cmt_full = r_next.stat & {i_cmt_mask[`PMC_CMT_TCO],
                                  i_cmt_mask[`PMC_CMT_STE]};
        r_next.connection_service_event = |cmt_full; // R14
        // aux clock divider, rate switched only at the low boundary
        r_next.div_cnt = r_reg.div_cnt + 2'h1;
        if (r_next.div_cnt == 2'h0) begin
            r_next.aux_sel = r_reg.mode[`PMC_MODE_AUX_CLOCK_RATE_SELECT]; // R09
        end
        r_next.aux_clk = r_next.aux_sel ? r_next.div_cnt[0]
                                        : r_next.div_cnt[1]; // R08
    end

    // state register, synchronous reset
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            r_reg <= '0;
            r_reg.mode <= `PMC_MODE_RST; // R08
            r_reg.stat <= `PMC_CMT_RST;
        end else begin
            r_reg <= r_next;
        end
    end

    // outputs straight from the state register
    assign o_cb = r_reg.rsp;
    assign o_phy_func_rst = r_reg.mode[`PMC_MODE_SRST]; // R02
    assign o_aux_clock_output = r_reg.aux_clk;
    assign o_par_err_set = r_reg.par_err;
    assign o_cwi_set = r_reg.conditional_write_inhibit;
    assign o_cse_set = r_reg.connection_service_event;
    assign o_tx_mode_load = r_reg.tx_load;
    assign o_tx_mode = r_reg.tx_mode;
    assign o_cfg_load = r_reg.cfg_load;
    assign o_cfg = r_reg.cfg;
    assign o_scrub_ports = r_reg.scrub_ports;
    assign o_scrub_sym = r_reg.sym;
    assign o_port_cfg_protect = r_reg.stat[0]; // R16
    assign o_tx_state_protect = r_reg.stat[1]; // R18

    default clocking cb_def @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_n);

    sequence s_trig_quiet;
        trig_scrub ##1 (!i_trig_event)[*2];
    endsequence

    sequence s_mode_wr_busy;
        wr_acc && i_cb.addr == `PMC_OFS_MODE && o_phy_func_rst;
    endsequence

    AST_SRST_LEN: assert property ( // R03
        $rose(o_phy_func_rst) |-> o_phy_func_rst[*8] ##24 o_phy_func_rst
            ##1 !o_phy_func_rst)
        else $error("soft reset bit did not last 32 cycles");

    AST_MODE_LOCK: assert property ( // R01
        s_mode_wr_busy |=> $stable(r_reg.mode[7:1]))
        else $error("mode written while phy in reset");

    AST_SRST_ZERO: assert property ( // R04
        wr_acc && i_cb.addr == `PMC_OFS_MODE && !i_cb.data[0]
            && o_phy_func_rst && r_reg.srst_cnt != SRST_LAST
            |=> o_phy_func_rst)
        else $error("zero write cleared soft reset");

    AST_PAR_ERR: assert property ( // R06
        i_cb.sel && i_cb.wr && r_reg.mode[`PMC_MODE_HOST_BUS_PARITY_CHECK_ENABLE]
            && i_cb.par != (^i_cb.data ^ PAR_ODD)
            |=> o_par_err_set && $stable(r_reg.mode[7:1])
                && $stable(r_reg.cmp))
        else $error("parity error not flagged or access kept");

    AST_NO_PAR: assert property ( // R05
        !r_reg.mode[`PMC_MODE_HOST_BUS_PARITY_CHECK_ENABLE] |=> !o_par_err_set)
        else $error("parity error with checking disabled");

    AST_RPAR: assert property ( // R07
        o_cb.ack |-> o_cb.par == (^o_cb.data ^ PAR_ODD))
        else $error("read parity wrong");

    AST_GLITCH: assert property ( // R09
        $changed(r_reg.aux_sel) |-> !o_aux_clock_output
            && $past(o_aux_clock_output))
        else $error("aux clock rate switched off boundary");

    AST_SCRUB: assert property ( // R11
        s_trig_quiet |=> o_scrub_sym == pmc_pkg::SYM_SCRUB
            && $past(o_scrub_sym, 2) == pmc_pkg::SYM_INVALID
            && o_cfg_load == 1'b0)
        else $error("scrub did not start with two invalid symbols");

    AST_CMP_COPY: assert property ( // R12
        rd_acc && i_cb.addr == `PMC_OFS_STAT |=> r_reg.cmp == $past(r_reg.stat))
        else $error("status read did not update comparison");

    AST_CWI: assert property ( // R13
        wr_acc && i_cb.addr == `PMC_OFS_STAT && r_reg.stat != r_reg.cmp
            |=> o_cwi_set)
        else $error("inhibit not raised on mismatch");

    AST_STE: assert property ( // R15
        tmr_exp |=> o_port_cfg_protect ##0 o_scrub_sym == pmc_pkg::SYM_NONE
            || $past(i_trig_event))
        else $error("timer expiry not recorded");

    AST_TCO: assert property ( // R17
        i_trig_event |=> o_tx_state_protect && o_tx_mode_load
            && o_tx_mode == $past(i_trig_tx_mode))
        else $error("trigger not recorded");

    AST_CSE: assert property ( // R14
        o_cse_set == |({o_tx_state_protect, o_port_cfg_protect}
            & $past({i_cmt_mask[7], i_cmt_mask[6]})))
        else $error("service event does not follow status and mask");

    // scrub start, bus answer and reserved read bits
    AST_CFG_LOAD: assert property ( // R10
        trig_scrub |=> o_cfg_load && o_cfg == $past(i_trans_cfg)
            && o_scrub_ports == $past(i_trans_cfg ^ i_port_cfg))
        else $error("scrub start did not load configuration");

    AST_NO_CFG: assert property ( // R10
        i_trig_event && !r_reg.mode[`PMC_MODE_SCRUB_ON_TRIGGER_ENABLE] |=> !o_cfg_load)
        else $error("configuration loaded with scrubbing off");

    AST_ACK: assert property ( // R07
        i_cb.sel |=> o_cb.ack)
        else $error("control bus access not answered");

    AST_RSVD_RD: assert property ( // R22
        rd_acc && i_cb.addr != `PMC_OFS_MODE
            |=> o_cb.data[5:0] == 6'h00)
        else $error("reserved condition bits read nonzero");

    AST_RSVD_MODE: assert property ( // R22
        rd_acc && i_cb.addr == `PMC_OFS_MODE
            |=> (o_cb.data & 8'h5c) == 8'h00)
        else $error("reserved mode bits read nonzero");

    // soft reset start and conditional status write
    sequence s_stat_wr_quiet;
        wr_acc && i_cb.addr == `PMC_OFS_STAT && !tmr_exp && !i_trig_event;
    endsequence

    AST_SRST_SET: assert property ( // R04
        wr_acc && i_cb.addr == `PMC_OFS_MODE && i_cb.data[0]
            && !o_phy_func_rst |=> o_phy_func_rst)
        else $error("soft reset bit not set by write");

    AST_CWI_KEEP: assert property ( // R13
        s_stat_wr_quiet ##0 r_reg.stat != r_reg.cmp
            |=> $stable(r_reg.stat))
        else $error("inhibited status write changed bits");

    AST_STAT_WR: assert property ( // R13
        s_stat_wr_quiet ##0 r_reg.stat == r_reg.cmp
            |=> r_reg.stat == $past(cmt_wr) && !o_cwi_set)
        else $error("matching status write not applied");

    // scrub timer and aux clock rates
    AST_THR_HOLD: assert property ( // R20
        !tick_done && !trig_scrub |=> $stable(r_reg.thr_cnt))
        else $error("scrub threshold count moved between ticks");

    AST_AUX_FAST: assert property ( // R08
        r_reg.aux_sel && $past(r_reg.aux_sel)
            |-> o_aux_clock_output != $past(o_aux_clock_output))
        else $error("aux clock not at the fast rate");

    AST_AUX_SLOW: assert property ( // R08
        !r_reg.aux_sel && !$past(r_reg.aux_sel) && $past(i_rst_n)
            |-> (o_aux_clock_output == $past(o_aux_clock_output))
                == r_reg.div_cnt[0])
        else $error("aux clock not at the slow rate");
endmodule

// *** pmc_regs.svh ***
// offsets, bit positions, reset values and timing counts of the block
`ifndef PMC_REGS_SVH
`define PMC_REGS_SVH
`define PMC_OFS_MODE    6'h1e
`define PMC_OFS_CMP     6'h1f
`define PMC_OFS_STAT    6'h20
`define PMC_MODE_SRST   0
`define PMC_MODE_HOST_BUS_PARITY_CHECK_ENABLE   1
`define PMC_MODE_AUX_CLOCK_RATE_SELECT 5
`define PMC_MODE_SCRUB_ON_TRIGGER_ENABLE   7
`define PMC_CMT_STE     6
`define PMC_CMT_TCO     7
`define PMC_MODE_RST    8'h00
`define PMC_CMT_RST     2'h0
`define PMC_SRST_CYC    32
`define PMC_CLK_NS      100
`define PMC_TICK_NS     40960
`define PMC_TICK_CYC    (`PMC_TICK_NS / `PMC_CLK_NS)
`endif

// *** tb.sv ***
// self-checking bench for the mode and cmt condition registers
`include "pmc_regs.svh"
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin mismatches++; \
    $display("mismatch at %0t got %h expected %h", $time, g, e); end end
module tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic                   i_ref_clk;
    logic                   i_rst_n;
    pmc_pkg::pmc_cbus_req_s cb_req;
    pmc_pkg::pmc_cbus_rsp_s cb_rsp;
    logic [7:0]             mask;
    logic                   trig;
    logic [2:0]             tmode;
    logic [7:0]             tcfg;
    logic [7:0]             pcfg;
    logic [7:0]             thr;
    logic                   frst, aux, perr, conditional_write_inhibit, connection_service_event, tld, cld, pprot, tprot;
    logic [2:0]             txm;
    logic [7:0]             cfg, ports;
    pmc_pkg::pmc_sym_e      sym;
    int                     mismatches;
    int                     num_checks;
    logic [7:0]             lfsr = 8'h44;

    pmc_host_model pmc_host_model_inst (.i_ref_clk(i_ref_clk),
        .i_cb_rsp(cb_rsp), .o_cb_req(cb_req));
    pmc_regs pmc_regs_inst (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n),
        .i_cb(cb_req), .o_cb(cb_rsp), .i_cmt_mask(mask),
        .i_trig_event(trig), .i_trig_tx_mode(tmode), .i_trans_cfg(tcfg),
        .i_port_cfg(pcfg), .i_scrub_threshold(thr),
        .o_phy_func_rst(frst), .o_aux_clock_output(aux),
        .o_par_err_set(perr), .o_cwi_set(conditional_write_inhibit), .o_cse_set(connection_service_event),
        .o_tx_mode_load(tld), .o_tx_mode(txm), .o_cfg_load(cld),
        .o_cfg(cfg), .o_scrub_ports(ports), .o_scrub_sym(sym),
        .o_port_cfg_protect(pprot), .o_tx_state_protect(tprot));

    // 10 MHz byte clock
    initial begin
        i_ref_clk = 1'b0;
        forever #50 i_ref_clk = ~i_ref_clk;
    end

    // next pseudo-random byte
    function automatic logic [7:0] lfsr_next(input logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction

    task automatic tally_and_finish();
        if (mismatches == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // register write with optional bad parity
    task automatic wr(input logic [5:0] a, input logic [7:0] d,
                      input logic bad);
        pmc_pkg::pmc_cbus_rsp_s r;
        pmc_host_model_inst.access(1'b1, a, d, bad, r);
        `CHK(r.ack, 1'b1)
    endtask

    // register read with data and parity check, service event check on status reads
    task automatic rd(input logic [5:0] a, input logic [7:0] e);
        pmc_pkg::pmc_cbus_rsp_s r;
        lfsr = lfsr_next(lfsr);
        pmc_host_model_inst.access(1'b0, a, lfsr, 1'b0, r);
        `CHK(r.data, e)
        `CHK(r.par, ~^e)
        if (a == `PMC_OFS_STAT)
            `CHK(connection_service_event, |(e[7:6] & mask[7:6]))
    endtask

    // trigger pulse with random mode and configurations
    task automatic fire(input logic scrub);
        int n;
        logic [2:0] m;
        logic [7:0] c, p;
        lfsr = lfsr_next(lfsr);
        m = lfsr[2:0];
        lfsr = lfsr_next(lfsr);
        c = lfsr;
        lfsr = lfsr_next(lfsr);
        p = lfsr;
        @(posedge i_ref_clk);
        trig <= 1'b1;
        tmode <= m;
        tcfg <= c;
        pcfg <= p;
        mask <= p ^ c;
        thr <= {6'h00, 1'b1, p[0]};
        @(posedge i_ref_clk);
        trig <= 1'b0;
        tmode <= ~m;
        #1;
        `CHK(tld, 1'b1)
        `CHK(txm, m)
        `CHK(tprot, 1'b1)
        `CHK(cld, scrub)
        if (scrub) begin
            `CHK(cfg, c)
            `CHK(ports, c ^ p)
        end
        for (n = 0; n < 2; n++) begin
            `CHK(sym, scrub ? pmc_pkg::SYM_INVALID : pmc_pkg::SYM_NONE)
            @(posedge i_ref_clk);
            #1;
        end
        n = 0;
        while (scrub && sym === pmc_pkg::SYM_SCRUB && n < 2000) begin
            n++;
            @(posedge i_ref_clk);
            #1;
        end
        if (scrub) begin
            `CHK(n, (int'(thr) + 1) * `PMC_TICK_CYC)
            `CHK(sym, pmc_pkg::SYM_NONE)
            `CHK(pprot, 1'b1)
            `CHK(ports, 8'h00)
        end
    endtask

    // watchdog cuts a hang short
    initial begin
        repeat (4000) @(posedge i_ref_clk);
        mismatches++;
        tally_and_finish();
    end

    // main sequence
    initial begin
        int n;
        logic a;
        i_rst_n = 1'b0;
        {mask, trig, tmode, tcfg, pcfg, thr} = '0;
        repeat (6) @(posedge i_ref_clk);
        i_rst_n <= 1'b1;
        rd(`PMC_OFS_MODE, 8'h00);
        rd(`PMC_OFS_STAT, 8'h00);
        rd(6'h2a, 8'h00);
        wr(`PMC_OFS_MODE, 8'h22, 1'b0);
        rd(`PMC_OFS_MODE, 8'h22);
        // rate change waits for the divider to wrap
        repeat (4) @(posedge i_ref_clk);
        #1;
        a = aux;
        @(posedge i_ref_clk);
        #1;
        `CHK(aux, ~a)
        wr(`PMC_OFS_MODE, 8'h80, 1'b1);
        `CHK(perr, 1'b1)
        rd(`PMC_OFS_MODE, 8'h22);
        wr(`PMC_OFS_MODE, 8'h20, 1'b0);
        wr(`PMC_OFS_MODE, 8'h22, 1'b1);
        `CHK(perr, 1'b0)
        rd(`PMC_OFS_MODE, 8'h22);
        wr(`PMC_OFS_MODE, 8'h23, 1'b0);
        `CHK(frst, 1'b1)
        wr(`PMC_OFS_MODE, 8'h80, 1'b0);
        for (n = 0; frst === 1'b1 && n < 100; n++) begin
            @(posedge i_ref_clk);
            #1;
        end
        `CHK(n, `PMC_SRST_CYC - 2)
        rd(`PMC_OFS_MODE, 8'h22);
        fire(1'b0);
        rd(`PMC_OFS_STAT, 8'h80);
        wr(`PMC_OFS_MODE, 8'ha2, 1'b0);
        fire(1'b1);
        wr(`PMC_OFS_STAT, 8'h00, 1'b0);
        `CHK(conditional_write_inhibit, 1'b1)
        rd(`PMC_OFS_STAT, 8'hc0);
        wr(`PMC_OFS_STAT, 8'h00, 1'b0);
        `CHK(conditional_write_inhibit, 1'b0)
        rd(`PMC_OFS_STAT, 8'h00);
        tally_and_finish();
    end
endmodule
